// ### rtl/uart_line_control_status.sv
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module uart_line_control_status (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic [4:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [3:0]  i_byteenable,
  input  wire logic [31:0] i_writedata,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  input  wire logic        i_rx_serial,
  input  wire logic        i_cts_n,
  input  wire logic        i_dsr_n,
  input  wire logic        i_ring_n,
  input  wire logic        i_carrier_n,
  output logic             o_tx_serial,
  output logic             o_dtr_n,
  output logic             o_rts_n,
  output logic             o_irq,
  output logic             o_irq_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT} rx_state_e;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  format;
    logic [7:0]  modem;
    logic [3:0]  int_en;
    logic [7:0]  scratch;
    logic [15:0] divisor;
    logic [15:0] div_cnt;
    logic        tx_pending;
    logic        tx_ident_clr;
    logic [7:0]  thr;
    logic        thr_full;
    tx_state_e   tx_st;
    logic [11:0] tx_shift;
    logic [3:0]  tx_bits;
    logic [3:0]  tx_tick;
    logic        tx_half;
    logic        tx_out;
    rx_state_e   rx_st;
    logic [3:0]  rx_tick;
    logic [3:0]  rx_bits;
    logic [9:0]  rx_shift;
    logic        rx_allzero;
    logic [7:0]  rbr;
    logic        rx_ready;
    logic        overrun;
    logic        par_err;
    logic        frm_err;
    logic        brk;
    logic [3:0]  mlines;
    logic [3:0]  mdelta;
    logic        rx_in;
  } state_s;

  state_s st;
  state_s next_st;

  logic [3:0]  nbits;
  logic [3:0]  ldelta;
  logic        par_bit;
  logic        tick;
  logic        rx_src;
  logic [3:0]  mnow;
  logic [7:0]  ident;
  logic [7:0]  lstat;
  logic [7:0]  wbyte;
  logic        req;
  logic        is_wr;
  logic        is_rd;
  logic        div_sel;
  logic [4:0]  stop_ticks;
  logic [7:0]  tx_mask;
  logic [7:0]  rx_data;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // bit 0 weighs two and bit 1 weighs one in the length code
    nbits   = 4'h5 + {2'h0, st.format[uart_lcs_pkg::FMT_LEN_LO], st.format[uart_lcs_pkg::FMT_LEN_HI]};
    tx_mask = 8'hFF >> (4'h8 - nbits);
    // with parity the data sits one place lower in the shifter, under the parity bit
    rx_data = (st.format[uart_lcs_pkg::FMT_PAR_EN] ? st.rx_shift[8:1] : st.rx_shift[9:2])
              >> (4'h8 - nbits);
    div_sel = st.format[uart_lcs_pkg::FMT_DIV_SEL];
    tick    = (st.div_cnt == 16'h0000);
    // loopback feeds the receiver from the transmit shifter and ignores the pin
    rx_src  = st.modem[uart_lcs_pkg::MC_LOOP] ? st.tx_out : st.rx_in;
    // modem lines as active-high: cts, dsr, ring, carrier
    if (st.modem[uart_lcs_pkg::MC_LOOP]) begin
      mnow = {st.modem[uart_lcs_pkg::MC_AUX], st.modem[uart_lcs_pkg::MC_RING],
              st.modem[uart_lcs_pkg::MC_DTR], st.modem[uart_lcs_pkg::MC_RTS]};
    end else begin
      mnow = {~i_carrier_n, ~i_ring_n, ~i_dsr_n, ~i_cts_n};
    end
    // interrupt priority
    ldelta = st.mdelta;
    if (st.int_en[uart_lcs_pkg::IE_LS] && (st.overrun || st.par_err || st.frm_err || st.brk)) begin
      ident = {5'h00, uart_lcs_pkg::ID_LINE};
    end else if (st.int_en[uart_lcs_pkg::IE_RX] && st.rx_ready) begin
      ident = {5'h00, uart_lcs_pkg::ID_RX};
    end else if (st.int_en[uart_lcs_pkg::IE_TX] && st.tx_pending) begin
      ident = {5'h00, uart_lcs_pkg::ID_TX};
    end else if (st.int_en[uart_lcs_pkg::IE_MS] && (ldelta != 4'h0)) begin
      ident = {5'h00, uart_lcs_pkg::ID_MS};
    end else begin
      ident = {5'h00, uart_lcs_pkg::ID_NONE};
    end
    lstat = {1'b0, ~st.thr_full && (st.tx_st == TX_IDLE), ~st.thr_full,
             st.brk, st.frm_err, st.par_err, st.overrun, st.rx_ready};
    req   = (i_read || i_write) && !st.ack;
    // a write lands at the accepting edge, where the master sees waitrequest low
    is_wr = i_write && st.ack && i_byteenable[0];
    is_rd = i_read && req;
    wbyte = i_writedata[7:0];
    par_bit = st.format[uart_lcs_pkg::FMT_FORCE] ? ~st.format[uart_lcs_pkg::FMT_EVEN]
            : (^(st.thr & tx_mask)) ^ ~st.format[uart_lcs_pkg::FMT_EVEN];
    // one and a half stop bits only for five-bit words
    if (!st.format[uart_lcs_pkg::FMT_STOP]) begin
      stop_ticks = 5'h10;
    end else if (nbits == 4'h5) begin
      stop_ticks = 5'h18;
    end else begin
      stop_ticks = 5'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st       = st;
    next_st.ack   = req;
    next_st.rdata = 32'h0000_0000;
    next_st.rx_in = i_rx_serial;
    next_st.div_cnt = tick ? st.divisor - 16'h0001 : st.div_cnt - 16'h0001;

    // modem change detection; ring reports only its trailing edge
    next_st.mlines = mnow;
    next_st.mdelta = st.mdelta | ((mnow ^ st.mlines) & 4'b1011) | ({4{1'b0}} | {1'b0, st.mlines[2] & ~mnow[2], 2'b00});

    // transmitter
    next_st.tx_out = 1'b1;
    unique case (st.tx_st)
      TX_IDLE: begin
        if (st.thr_full) begin
          // everything above the data is preset to mark, so short words get proper stop bits
          next_st.tx_shift = (12'hFFF << (nbits + 4'h1)) | {3'b000, st.thr & tx_mask, 1'b0};
          next_st.tx_shift[nbits + 4'h1] = st.format[uart_lcs_pkg::FMT_PAR_EN] ? par_bit : 1'b1;
          next_st.thr_full   = 1'b0;
          next_st.tx_pending = 1'b1;
          next_st.tx_bits    = nbits + 4'h1 + {3'h0, st.format[uart_lcs_pkg::FMT_PAR_EN]} + 4'h1;
          next_st.tx_tick    = 4'h0;
          next_st.tx_half    = 1'b0;
          next_st.tx_st      = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        next_st.tx_out = st.tx_shift[0];
        if (tick) begin
          next_st.tx_tick = st.tx_tick + 4'h1;
          if (st.tx_tick == uart_lcs_pkg::TICKS_LAST ||
              (st.tx_bits == 4'h1 && st.tx_half && st.tx_tick == uart_lcs_pkg::TICKS_HALF)) begin
            next_st.tx_shift = {1'b1, st.tx_shift[11:1]};
            next_st.tx_tick  = 4'h0;
            if (st.tx_bits == 4'h1) begin
              if (stop_ticks != 5'h10 && !st.tx_half) begin
                next_st.tx_half = 1'b1;
                next_st.tx_bits = (stop_ticks == 5'h18) ? 4'h1 : 4'h1;
                if (stop_ticks == 5'h00) begin
                  next_st.tx_half = 1'b0;
                  next_st.tx_bits = 4'h0;
                  next_st.tx_tick = 4'h0;
                end
              end else begin
                next_st.tx_st = TX_IDLE;
              end
            end else if (st.tx_bits == 4'h0) begin
              next_st.tx_st = TX_IDLE;
            end else begin
              next_st.tx_bits = st.tx_bits - 4'h1;
            end
          end
        end
      end
      default: next_st.tx_st = TX_IDLE;
    endcase

    // receiver: sample mid-bit, stop checked at first stop bit only
    if (tick) begin
      unique case (st.rx_st)
        RX_IDLE: begin
          if (!rx_src) begin
            next_st.rx_st      = RX_SHIFT;
            next_st.rx_tick    = 4'h0;
            next_st.rx_bits    = 4'h0;
            next_st.rx_allzero = 1'b1;
          end
        end
        RX_SHIFT: begin
          next_st.rx_tick = st.rx_tick + 4'h1;
          if (st.rx_tick == uart_lcs_pkg::TICKS_HALF) begin
            next_st.rx_shift   = {rx_src, st.rx_shift[9:1]};
            next_st.rx_bits    = st.rx_bits + 4'h1;
            next_st.rx_allzero = st.rx_allzero & ~rx_src;
            // a start bit gone by mid-bit is taken as noise
            if (st.rx_bits == 4'h0 && rx_src) begin
              next_st.rx_st = RX_IDLE;
            end else if (st.rx_bits == nbits + 4'h1 + {3'h0, st.format[uart_lcs_pkg::FMT_PAR_EN]}) begin
              next_st.rx_st    = RX_IDLE;
              next_st.rbr      = rx_data;
              next_st.rx_ready = 1'b1;
              if (st.rx_ready) begin
                next_st.overrun = 1'b1;
              end
              if (!rx_src) begin
                next_st.frm_err = 1'b1;
              end
              if (st.rx_allzero && !rx_src) begin
                next_st.brk = 1'b1;
              end
              if (st.format[uart_lcs_pkg::FMT_PAR_EN]) begin
                if (st.format[uart_lcs_pkg::FMT_FORCE]) begin
                  if (st.rx_shift[9] != ~st.format[uart_lcs_pkg::FMT_EVEN]) begin
                    next_st.par_err = 1'b1;
                  end
                end else if (((^rx_data) ^ st.rx_shift[9]) == st.format[uart_lcs_pkg::FMT_EVEN]) begin
                  next_st.par_err = 1'b1;
                end
              end
            end
          end
        end
        default: next_st.rx_st = RX_IDLE;
      endcase
    end

    // register reads; clears happen with the read, and hardware sets above win only for flags that were clear before
    if (is_rd) begin
      unique case (i_address)
        uart_lcs_pkg::OFF_DATA: begin
          next_st.rdata = {24'h0, div_sel ? st.divisor[7:0] : st.rbr};
          if (!div_sel && next_st.rx_ready == st.rx_ready) begin
            next_st.rx_ready = 1'b0;
          end
        end
        uart_lcs_pkg::OFF_INT_EN: begin
          next_st.rdata = {24'h0, div_sel ? st.divisor[15:8] : {4'h0, st.int_en}};
        end
        uart_lcs_pkg::OFF_IDENT: begin
          next_st.rdata = {24'h0, ident};
          if (ident[2:0] == uart_lcs_pkg::ID_TX && next_st.tx_pending == st.tx_pending) begin
            next_st.tx_pending = 1'b0;
          end
        end
        uart_lcs_pkg::OFF_FORMAT: begin
          next_st.rdata = {24'h0, st.format};
        end
        uart_lcs_pkg::OFF_MODEM: begin
          next_st.rdata = {24'h0, 3'h0, st.modem[4:0]};
        end
        uart_lcs_pkg::OFF_LSTAT: begin
          next_st.rdata   = {24'h0, lstat};
          next_st.overrun = next_st.overrun & ~st.overrun;
          next_st.par_err = next_st.par_err & ~st.par_err;
          next_st.frm_err = next_st.frm_err & ~st.frm_err;
          next_st.brk     = next_st.brk & ~st.brk;
        end
        uart_lcs_pkg::OFF_MSTAT: begin
          next_st.rdata  = {24'h0, st.mlines, st.mdelta};
          next_st.mdelta = next_st.mdelta & ~st.mdelta;
        end
        uart_lcs_pkg::OFF_SCRATCH: begin
          next_st.rdata = {24'h0, st.scratch};
        end
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end

    if (is_wr) begin
      unique case (i_address)
        uart_lcs_pkg::OFF_DATA: begin
          if (div_sel) begin
            next_st.divisor[7:0] = wbyte;
          end else begin
            next_st.thr        = wbyte;
            next_st.thr_full   = 1'b1;
            next_st.tx_pending = 1'b0;
          end
        end
        uart_lcs_pkg::OFF_INT_EN: begin
          if (div_sel) begin
            next_st.divisor[15:8] = wbyte;
          end else begin
            next_st.int_en = wbyte[3:0];
          end
        end
        uart_lcs_pkg::OFF_FORMAT: begin
          next_st.format = wbyte;
        end
        uart_lcs_pkg::OFF_MODEM: begin
          next_st.modem = {3'h0, wbyte[4:0]};
        end
        uart_lcs_pkg::OFF_SCRATCH: begin
          next_st.scratch = wbyte;
        end
        default: next_st.scratch = st.scratch;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st         <= '0;
      st.format  <= uart_lcs_pkg::FORMAT_RST;
      st.modem   <= uart_lcs_pkg::MODEM_RST;
      st.int_en  <= uart_lcs_pkg::INT_EN_RST[3:0];
      st.divisor <= uart_lcs_pkg::DIVISOR_RST;
      st.tx_out  <= 1'b1;
      st.rx_in   <= 1'b1;
      st.tx_st   <= TX_IDLE;
      st.rx_st   <= RX_IDLE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // waitrequest drops one cycle after the request, when read data is registered
  assign o_waitrequest = (i_read || i_write) && !st.ack;
  assign o_readdata    = st.rdata;
  assign o_tx_serial   = st.modem[uart_lcs_pkg::MC_LOOP] ? 1'b1 :
                         (st.format[uart_lcs_pkg::FMT_BREAK] ? 1'b0 : st.tx_out);
  assign o_dtr_n       = st.modem[uart_lcs_pkg::MC_LOOP] | ~st.modem[uart_lcs_pkg::MC_DTR];
  assign o_rts_n       = st.modem[uart_lcs_pkg::MC_LOOP] | ~st.modem[uart_lcs_pkg::MC_RTS];
  // gate is modem bit 3 only outside loopback; in loopback the output stays enabled
  assign o_irq_oe      = st.modem[uart_lcs_pkg::MC_LOOP] | st.modem[uart_lcs_pkg::MC_AUX];
  assign o_irq         = ~ident[0];

endmodule

// ### include/uart_lcs_pkg.sv
package uart_lcs_pkg;
  // register offsets, byte addresses on a 32-bit avalon bus (index * 4)
  localparam logic [4:0] OFF_DATA     = 5'h00;
  localparam logic [4:0] OFF_INT_EN   = 5'h04;
  localparam logic [4:0] OFF_IDENT    = 5'h08;
  localparam logic [4:0] OFF_FORMAT   = 5'h0C;
  localparam logic [4:0] OFF_MODEM    = 5'h10;
  localparam logic [4:0] OFF_LSTAT    = 5'h14;
  localparam logic [4:0] OFF_MSTAT    = 5'h18;
  localparam logic [4:0] OFF_SCRATCH  = 5'h1C;
  // line format fields
  localparam int FMT_LEN_LO  = 0;
  localparam int FMT_LEN_HI  = 1;
  localparam int FMT_STOP    = 2;
  localparam int FMT_PAR_EN  = 3;
  localparam int FMT_EVEN    = 4;
  localparam int FMT_FORCE   = 5;
  localparam int FMT_BREAK   = 6;
  localparam int FMT_DIV_SEL = 7;
  // modem control fields
  localparam int MC_DTR  = 0;
  localparam int MC_RTS  = 1;
  localparam int MC_RING = 2;
  localparam int MC_AUX  = 3;
  localparam int MC_LOOP = 4;
  // interrupt enable fields
  localparam int IE_RX = 0;
  localparam int IE_TX = 1;
  localparam int IE_LS = 2;
  localparam int IE_MS = 3;
  // identification codes
  localparam logic [2:0] ID_NONE = 3'h1;
  localparam logic [2:0] ID_LINE = 3'h6;
  localparam logic [2:0] ID_RX   = 3'h4;
  localparam logic [2:0] ID_TX   = 3'h2;
  localparam logic [2:0] ID_MS   = 3'h0;
  // reset values
  localparam logic [7:0]  FORMAT_RST  = 8'h00;
  localparam logic [7:0]  MODEM_RST   = 8'h00;
  localparam logic [7:0]  INT_EN_RST  = 8'h00;
  localparam logic [15:0] DIVISOR_RST = 16'h0001;
  // serial timing: 16 ticks per bit, tick = divisor clocks
  localparam logic [3:0] TICKS_HALF = 4'h7;
  localparam logic [3:0] TICKS_LAST = 4'hF;
endpackage

// ### dv/uart_lcs_chk.sv
`timescale 1ns/1ps
module uart_lcs_chk (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic [4:0]  i_address,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic [3:0]  i_byteenable,
  input wire logic [31:0] i_writedata,
  input wire logic [31:0] o_readdata,
  input wire logic        o_waitrequest,
  input wire logic        o_tx_serial,
  input wire logic        o_dtr_n,
  input wire logic        o_rts_n,
  input wire logic        o_irq_oe
);
  // shadows load on the accepting edge, the same edge as the block's own registers
  logic [7:0] mc;
  logic [7:0] fmt;
  logic       wok;
  logic       rok;
  assign wok = i_write && !o_waitrequest && i_byteenable[0];
  assign rok = i_read && !o_waitrequest;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mc  <= 8'h00;
      fmt <= 8'h00;
    end else begin
      if (wok && i_address == uart_lcs_pkg::OFF_MODEM) mc <= i_writedata[7:0];
      if (wok && i_address == uart_lcs_pkg::OFF_FORMAT) fmt <= i_writedata[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking dc @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wait_first_a: assert property (($rose(i_read) || $rose(i_write)) |-> o_waitrequest) else $error("no wait state");
  answer_next_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest) else $error("late answer");
  upper_zero_a: assert property (rok |-> o_readdata[31:8] == 24'h000000) else $error("upper bytes set");
  ident_code_a: assert property (
    rok && i_address == uart_lcs_pkg::OFF_IDENT |-> o_readdata[7:3] == 5'h00 &&
    o_readdata[2:0] inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h6} && o_readdata[0] == (o_readdata[2:0] == 3'h1))
    else $error("bad ident");
  modem_rsv_a: assert property (rok && i_address == uart_lcs_pkg::OFF_MODEM |-> o_readdata[7:5] == 3'h0)
    else $error("modem control high bits set");
  lstat_rsv_a: assert property (rok && i_address == uart_lcs_pkg::OFF_LSTAT |-> !o_readdata[7])
    else $error("line status bit 7 set");
  gate_pin_a: assert property (o_irq_oe == (mc[3] || mc[4])) else $error("irq enable wrong");
  modem_pin_a: assert property (
    o_dtr_n == !(mc[0] && !mc[4]) && o_rts_n == !(mc[1] && !mc[4])) else $error("modem pins wrong");
  // one settled cycle is allowed, the serial pin may be registered
  loop_mark_a: assert property (mc[4] && $past(mc[4]) |-> o_tx_serial) else $error("loop not marking");
  break_low_a: assert property (
    fmt[6] && $past(fmt[6]) && !mc[4] && !$past(mc[4]) |-> !o_tx_serial) else $error("break not spacing");
endmodule
bind uart_line_control_status uart_lcs_chk u_chk (
  .i_clock(i_clock), .i_rst(i_rst), .i_address(i_address), .i_read(i_read), .i_write(i_write),
  .i_byteenable(i_byteenable), .i_writedata(i_writedata), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest), .o_tx_serial(o_tx_serial), .o_dtr_n(o_dtr_n), .o_rts_n(o_rts_n),
  .o_irq_oe(o_irq_oe));

// ### dv/uart_far_end.sv
`timescale 1ns/1ps
module uart_far_end (
  input  wire logic  i_clock,
  output logic       o_serial,
  output logic [3:0] o_modem_n
);
  // line idles at mark, modem lines inactive: {carrier, ring, dsr, cts}
  initial begin
    o_serial  = 1'b1;
    o_modem_n = 4'hF;
  end
  // divisor 1 with 16 ticks a bit gives 16 clocks a bit
  task automatic put_bit(input logic b);
    o_serial <= b;
    repeat (16) @(posedge i_clock);
  endtask
  task automatic send(input logic [7:0] d, input int n, input logic pe, input logic p, input logic s);
    @(posedge i_clock);
    put_bit(1'b0);
    for (int k = 0; k < n; k++) put_bit(d[k]);
    if (pe) put_bit(p);
    put_bit(s);
    put_bit(1'b1);
  endtask
  task automatic set_modem(input logic [3:0] v);
    @(posedge i_clock);
    o_modem_n <= v;
  endtask
endmodule

// ### dv/test_uart_line_control_status.sv
`timescale 1ns/1ps
module test_uart_line_control_status;
  localparam logic [4:0] DA = uart_lcs_pkg::OFF_DATA;
  localparam logic [4:0] IE = uart_lcs_pkg::OFF_INT_EN;
  localparam logic [4:0] ID = uart_lcs_pkg::OFF_IDENT;
  localparam logic [4:0] FM = uart_lcs_pkg::OFF_FORMAT;
  localparam logic [4:0] MC = uart_lcs_pkg::OFF_MODEM;
  localparam logic [4:0] LS = uart_lcs_pkg::OFF_LSTAT;
  localparam logic [4:0] MS = uart_lcs_pkg::OFF_MSTAT;
  // frames: format, data, {parity bit, stop bit}, expected low status bits
  localparam logic [7:0] CF [11] = '{8'h1B, 8'h1B, 8'h0B, 8'h0B, 8'h3B, 8'h2B, 8'h03, 8'h07, 8'h02, 8'h01, 8'h10};
  localparam logic [7:0] CD [11] = '{8'h01, 8'h03, 8'h03, 8'h03, 8'h01, 8'h03, 8'hA5, 8'h00, 8'h2A, 8'h55, 8'h15};
  localparam logic [1:0] CP [11] = '{2'h1, 2'h1, 2'h3, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1};
  localparam logic [7:0] CE [11] = '{8'h05, 8'h01, 8'h01, 8'h05, 8'h01, 8'h05, 8'h09, 8'h19, 8'h01, 8'h01, 8'h01};
  logic        i_clock, i_rst, i_read, i_write, rx;
  logic [4:0]  i_address;
  logic [3:0]  i_byteenable, m_n;
  logic [31:0] i_writedata, o_readdata;
  logic        o_waitrequest, o_tx_serial, o_dtr_n, o_rts_n, o_irq, o_irq_oe;
  int          fails, num_checks;
  uart_line_control_status u_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_byteenable(i_byteenable), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_rx_serial(rx), .i_cts_n(m_n[0]), .i_dsr_n(m_n[1]),
    .i_ring_n(m_n[2]), .i_carrier_n(m_n[3]), .o_tx_serial(o_tx_serial), .o_dtr_n(o_dtr_n),
    .o_rts_n(o_rts_n), .o_irq(o_irq), .o_irq_oe(o_irq_oe));
  uart_far_end u_far (.i_clock(i_clock), .o_serial(rx), .o_modem_n(m_n));
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // request stands until the rising edge that samples waitrequest low; data is taken there
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge i_clock);
    i_address    <= a;
    i_writedata  <= {24'h000000, d};
    i_byteenable <= 4'h1;
    i_write      <= wr;
    i_read       <= !wr;
    @(posedge i_clock);
    while (o_waitrequest !== 1'b0 && n < 50) begin
      @(posedge i_clock);
      n++;
    end
    q = o_readdata[7:0];
    if (n == 50) check(32'h0, 32'h1);
    i_write <= 1'b0;
    i_read  <= 1'b0;
    // pins are looked at only once the accepted write has settled
    @(negedge i_clock);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check({24'h0, q & m}, {24'h0, e});
  endtask
  // a status read clears sticky flags, so only the first read showing them can match
  task automatic poll(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] q;
    int n;
    n = 0;
    bus(1'b0, a, 8'h00, q);
    while ((q & m) !== e && n < 200) begin
      bus(1'b0, a, 8'h00, q);
      n++;
    end
    check({24'h0, q & m}, {24'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(FM, 8'h00, 8'hFF);
    rdc(ID, 8'h01, 8'hFF);
    rdc(LS, 8'h60, 8'hFF);
    check({27'h0, o_dtr_n, o_rts_n, o_irq_oe, o_tx_serial, o_irq}, 32'h1A);
  endtask
  task automatic t_modem;
    wr(MC, 8'hE3);
    rdc(MC, 8'h03, 8'hFF);
    check({30'h0, o_dtr_n, o_rts_n}, 32'h0);
    wr(MC, 8'h08);
    check({30'h0, o_irq_oe, o_dtr_n}, 32'h3);
    u_far.set_modem(4'hE);
    rdc(MS, 8'h11, 8'hFF);
  endtask
  task automatic t_divisor;
    wr(IE, 8'h05);
    wr(FM, 8'h83);
    rdc(DA, 8'h01, 8'hFF);
    wr(IE, 8'h00);
    wr(FM, 8'h03);
    rdc(IE, 8'h05, 8'hFF);
    wr(IE, 8'h00);
  endtask
  task automatic t_frames;
    int n;
    for (int i = 0; i < 11; i++) begin
      n = 5 + int'({CF[i][0], CF[i][1]});
      wr(FM, CF[i]);
      u_far.send(CD[i], n, CF[i][3], CP[i][1], CP[i][0]);
      poll(LS, CE[i], 8'h1F);
      rdc(LS, 8'h01, 8'h1F);
      rdc(DA, CD[i] & 8'((1 << n) - 1), 8'hFF);
      rdc(LS, 8'h00, 8'h01);
    end
  endtask
  task automatic t_break;
    wr(FM, 8'h03);
    wr(DA, 8'h00);
    poll(LS, 8'h20, 8'h20);
    wr(FM, 8'h43);
    check({31'h0, o_tx_serial}, 32'h0);
    wr(DA, 8'h00);
    rdc(LS, 8'h00, 8'h60);
    poll(LS, 8'h60, 8'h60);
    wr(FM, 8'h03);
    check({31'h0, o_tx_serial}, 32'h1);
  endtask
  // loopback: second byte overwrites the first, then sources are served by rank
  task automatic t_prio;
    wr(MC, 8'h10);
    rdc(MS, 8'h00, 8'hF0);
    wr(MC, 8'h18);
    wr(IE, 8'h0F);
    wr(DA, 8'h11);
    poll(LS, 8'h01, 8'h01);
    wr(DA, 8'h22);
    poll(ID, 8'h06, 8'hFF);
    check({31'h0, o_irq}, 32'h1);
    rdc(LS, 8'h03, 8'h1F);
    rdc(ID, 8'h04, 8'hFF);
    rdc(DA, 8'h22, 8'hFF);
    rdc(ID, 8'h02, 8'hFF);
    rdc(ID, 8'h00, 8'hFF);
    rdc(MS, 8'h88, 8'hFF);
    rdc(ID, 8'h01, 8'hFF);
    check({31'h0, o_irq}, 32'h0);
  endtask
  // loopback round trips with short words, parity and the longer stop options
  task automatic t_loop;
    wr(FM, 8'h1C);
    wr(DA, 8'h13);
    poll(LS, 8'h01, 8'h1F);
    rdc(DA, 8'h13, 8'hFF);
    poll(LS, 8'h60, 8'h60);
    wr(FM, 8'h0E);
    wr(DA, 8'h2D);
    poll(LS, 8'h01, 8'h1F);
    rdc(DA, 8'h2D, 8'hFF);
    poll(LS, 8'h60, 8'h60);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    i_rst = 1'b1;
    i_read = 1'b0;
    i_write = 1'b0;
    i_address = 5'h00;
    i_byteenable = 4'h0;
    i_writedata = 32'h0;
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    t_reset;
    t_modem;
    t_divisor;
    t_frames;
    t_break;
    t_prio;
    t_loop;
    final_report;
  end
  // frames take about 200 clocks each, so this leaves a wide margin
  initial begin
    repeat (60000) @(posedge i_clock);
    fails++;
    final_report;
  end
endmodule
